// [src/mscr_cfg.svh]
// Constants of the model-specific counter register unit
`ifndef MSCR_CFG_SVH
`define MSCR_CFG_SVH

// Register indices carried in the index source register
`define MSCR_IDX_TEST_DATA    32'h0000_0003
`define MSCR_IDX_TEST_ADDR    32'h0000_0004
`define MSCR_IDX_TEST_CMD     32'h0000_0005
`define MSCR_IDX_STAMP        32'h0000_0010
`define MSCR_IDX_EVT_CTL      32'h0000_0011
`define MSCR_IDX_EVT_CNT0     32'h0000_0012
`define MSCR_IDX_EVT_CNT1     32'h0000_0013

// Event counter selectors for the read-counter instruction
`define MSCR_CNTR_SEL_0       32'h0000_0000
`define MSCR_CNTR_SEL_1       32'h0000_0001

// Instruction opcodes
`define MSCR_OPC_WRITE_MODEL  16'h0F30
`define MSCR_OPC_READ_STAMP   16'h0F31
`define MSCR_OPC_READ_MODEL   16'h0F32
`define MSCR_OPC_READ_EVENT   16'h0F33

// Widths
`define MSCR_DATA_W           64
`define MSCR_STAMP_W          64
`define MSCR_EVT_W            48
`define MSCR_REG_W            32
`define MSCR_SEL_W            7

// Event control field positions
`define MSCR_CNT1_TYPE_BIT    24
`define MSCR_CNT1_USER_EN_BIT 23
`define MSCR_CNT1_PRIV_EN_BIT 22
`define MSCR_CNT1_SEL_HI_BIT  26
`define MSCR_CNT1_SEL_LO_MSB  21
`define MSCR_CNT1_SEL_LO_LSB  16
`define MSCR_CNT0_TYPE_BIT    8
`define MSCR_CNT0_USER_EN_BIT 7
`define MSCR_CNT0_PRIV_EN_BIT 6
`define MSCR_CNT0_SEL_HI_BIT  10
`define MSCR_CNT0_SEL_LO_MSB  5
`define MSCR_CNT0_SEL_LO_LSB  0
`define MSCR_EVT_CTL_MASK     32'h05FF_05FF

// Reset values and privilege levels
`define MSCR_RST_REG          32'h0000_0000
`define MSCR_RST_STAMP        64'h0000_0000_0000_0000
`define MSCR_RST_EVT          48'h0000_0000_0000
`define MSCR_USER_LVL         2'h3
`define MSCR_TOP_LVL          2'h0

`endif

// [src/mscr_event_counter.sv]
// One event counter with type and privilege gating
`timescale 1ns/1ps
`include "mscr_cfg.svh"

module mscr_event_counter
   import mscr_pkg::*;
#(
   parameter int WIDTH = `MSCR_EVT_W
)
(
   // Clock and reset
   input  wire              core_clk,
   input  wire              nrst,
   input  wire              ce,
   // Control
   input  mscr_ctr_ctl_s    ctl,
   input  wire [1:0]        current_privilege_level,
   input  wire              event_hit,
   // Load from the data pair
   input  wire              wr_en,
   input  wire [WIDTH-1:0]  wr_data,
   // Count
   output logic [WIDTH-1:0] count_q
);

   logic lvl_ok;
   logic tick;

   // Both enables set makes privilege irrelevant; neither stops counting
   assign lvl_ok = (current_privilege_level == `MSCR_USER_LVL) ?
                   ctl.en_user : ctl.en_priv;
   // Type set counts every core clock, so it runs through Suspend too
   assign tick = lvl_ok && (ctl.ctype || event_hit);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         count_q <= '0;
      else if (ce)
      begin
         if (wr_en)
            count_q <= wr_data;
         else if (tick)
            count_q <= count_q + WIDTH'(1);
      end
   end

   AST_CNT_GATED: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && !wr_en && !lvl_ok) |=> $stable(count_q))
      else $error("event counter moved while disabled");

   AST_CNT_CLOCKS: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && !wr_en && lvl_ok && ctl.ctype)
      |=> count_q == $past(count_q) + WIDTH'(1))
      else $error("clock-type counter did not step");

endmodule // mscr_event_counter

// [src/mscr_pkg.sv]
// Types shared by the model-specific counter register unit
`include "mscr_cfg.svh"

package mscr_pkg;

   typedef enum logic [1:0] {
      MSCR_OP_READ_MODEL  = 2'b00,
      MSCR_OP_WRITE_MODEL = 2'b01,
      MSCR_OP_READ_STAMP  = 2'b10,
      MSCR_OP_READ_EVENT  = 2'b11
   } mscr_op_e;

   typedef struct packed {
      logic                     valid;
      logic [15:0]              opcode;
      logic [31:0]              index;
      logic [`MSCR_DATA_W-1:0]  wdata;
   } mscr_req_s;

   typedef struct packed {
      logic                     done;
      logic                     fault;
      logic [`MSCR_DATA_W-1:0]  rdata;
   } mscr_rsp_s;

   typedef struct packed {
      logic [`MSCR_SEL_W-1:0]   sel;
      logic                     ctype;
      logic                     en_user;
      logic                     en_priv;
   } mscr_ctr_ctl_s;

endpackage

// [src/mscr_priv_check.sv]
// Privilege gate for the four register instructions
`timescale 1ns/1ps
`include "mscr_cfg.svh"

module mscr_priv_check
   import mscr_pkg::*;
(
   // Instruction and state
   input  mscr_op_e    op,
   input  wire [1:0]   current_privilege_level,
   input  wire         stamp_restrict,
   input  wire         counter_open,
   // Verdict
   output logic        allowed
);

   logic at_top;

   assign at_top = (current_privilege_level == `MSCR_TOP_LVL);

   always_comb
   begin
      case (op)
         MSCR_OP_READ_MODEL,
         MSCR_OP_WRITE_MODEL: allowed = at_top;
         MSCR_OP_READ_STAMP:
            allowed = !stamp_restrict || at_top;
         MSCR_OP_READ_EVENT:
            allowed = counter_open || at_top;
         default: allowed = 1'b0;
      endcase
   end

endmodule // mscr_priv_check

// [src/mscr_unit.sv]
// Model-specific register unit: stamp, event control and counters
`timescale 1ns/1ps
`include "mscr_cfg.svh"

module mscr_unit
   import mscr_pkg::*;
#(
   parameter int EVT_W = `MSCR_EVT_W
)
(
   // Clock and reset
   input  wire                      core_clk,
   input  wire                      nrst,
   input  wire                      ce,
   // Instruction request from execution
   input  mscr_req_s                req,
   // Processor state
   input  wire [1:0]                current_privilege_level,
   input  wire                      stamp_restrict,
   input  wire                      counter_open,
   // Events chosen by the outside selector
   input  wire [1:0]                event_hit,
   // Answer to execution
   output mscr_rsp_s                rsp,
   // Event selectors for the outside selector
   output logic [`MSCR_SEL_W-1:0]   evt_sel0,
   output logic [`MSCR_SEL_W-1:0]   evt_sel1
);

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [`MSCR_STAMP_W-1:0] stamp_q;
   logic [`MSCR_REG_W-1:0]   tdata_q;
   logic [`MSCR_REG_W-1:0]   taddr_q;
   logic [`MSCR_REG_W-1:0]   tcmd_q;
   logic [`MSCR_REG_W-1:0]   ctl_q;
   logic [EVT_W-1:0]         cnt0_q;
   logic [EVT_W-1:0]         cnt1_q;
   mscr_rsp_s                rsp_q;
   mscr_ctr_ctl_s            ctl0;
   mscr_ctr_ctl_s            ctl1;

   mscr_op_e                 op;
   logic                     op_known;
   logic                     idx_map;
   logic                     target_ok;
   logic                     allowed;
   logic                     fault;
   logic                     do_wr;
   logic                     wr_tdata;
   logic                     wr_taddr;
   logic                     wr_tcmd;
   logic                     wr_stamp;
   logic                     wr_ctl;
   logic                     wr_cnt0;
   logic                     wr_cnt1;
   logic [`MSCR_DATA_W-1:0]  rd_val;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   always_comb
   begin
      op_known = 1'b1;
      case (req.opcode)
         `MSCR_OPC_READ_MODEL:  op = MSCR_OP_READ_MODEL;
         `MSCR_OPC_WRITE_MODEL: op = MSCR_OP_WRITE_MODEL;
         `MSCR_OPC_READ_STAMP:  op = MSCR_OP_READ_STAMP;
         `MSCR_OPC_READ_EVENT:  op = MSCR_OP_READ_EVENT;
         default:
         begin
            op       = MSCR_OP_READ_MODEL;
            op_known = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      case (req.index)
         `MSCR_IDX_TEST_DATA,
         `MSCR_IDX_TEST_ADDR,
         `MSCR_IDX_TEST_CMD:  idx_map = 1'b1;
         `MSCR_IDX_STAMP,
         `MSCR_IDX_EVT_CTL,
         `MSCR_IDX_EVT_CNT0,
         `MSCR_IDX_EVT_CNT1:  idx_map = 1'b1;
         default:             idx_map = 1'b0;
      endcase
   end

   always_comb
   begin
      case (op)
         MSCR_OP_READ_STAMP: target_ok = 1'b1;
         MSCR_OP_READ_EVENT:
            target_ok = (req.index == `MSCR_CNTR_SEL_0) ||
                        (req.index == `MSCR_CNTR_SEL_1);
         default:            target_ok = idx_map;
      endcase
   end

   mscr_priv_check u_priv (
      .op                      (op),
      .current_privilege_level (current_privilege_level),
      .stamp_restrict          (stamp_restrict),
      .counter_open            (counter_open),
      .allowed                 (allowed)
   );

   // A refused request writes nothing, so counters stay intact on fault
   assign fault = req.valid && !(op_known && allowed && target_ok);
   assign do_wr = req.valid && !fault && (op == MSCR_OP_WRITE_MODEL);

   assign wr_tdata = do_wr && (req.index == `MSCR_IDX_TEST_DATA);
   assign wr_taddr = do_wr && (req.index == `MSCR_IDX_TEST_ADDR);
   assign wr_tcmd  = do_wr && (req.index == `MSCR_IDX_TEST_CMD);
   assign wr_stamp = do_wr && (req.index == `MSCR_IDX_STAMP);
   assign wr_ctl   = do_wr && (req.index == `MSCR_IDX_EVT_CTL);
   assign wr_cnt0  = do_wr && (req.index == `MSCR_IDX_EVT_CNT0);
   assign wr_cnt1  = do_wr && (req.index == `MSCR_IDX_EVT_CNT1);

   ////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb
   begin
      rd_val = '0;
      case (op)
         MSCR_OP_READ_STAMP: rd_val = stamp_q;
         MSCR_OP_READ_EVENT:
            rd_val = (req.index == `MSCR_CNTR_SEL_1) ?
                     {{(`MSCR_DATA_W-EVT_W){1'b0}}, cnt1_q} :
                     {{(`MSCR_DATA_W-EVT_W){1'b0}}, cnt0_q};
         MSCR_OP_READ_MODEL:
         begin
            case (req.index)
               `MSCR_IDX_TEST_DATA: rd_val = {32'h0000_0000, tdata_q};
               `MSCR_IDX_TEST_ADDR: rd_val = {32'h0000_0000, taddr_q};
               `MSCR_IDX_TEST_CMD:  rd_val = {32'h0000_0000, tcmd_q};
               `MSCR_IDX_STAMP:     rd_val = stamp_q;
               `MSCR_IDX_EVT_CTL:   rd_val = {32'h0000_0000, ctl_q};
               `MSCR_IDX_EVT_CNT0:
                  rd_val = {{(`MSCR_DATA_W-EVT_W){1'b0}}, cnt0_q};
               `MSCR_IDX_EVT_CNT1:
                  rd_val = {{(`MSCR_DATA_W-EVT_W){1'b0}}, cnt1_q};
               default:             rd_val = '0;
            endcase
         end
         default: rd_val = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer, one cycle after the request

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rsp_q <= '0;
      else if (ce)
      begin
         rsp_q.done  <= req.valid;
         rsp_q.fault <= fault;
         rsp_q.rdata <= (req.valid && !fault) ? rd_val : '0;
      end
   end

   assign rsp = rsp_q;

   ////////////////////////////////////////////////////////////////////////
   // Test registers

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tdata_q <= `MSCR_RST_REG;
         taddr_q <= `MSCR_RST_REG;
         tcmd_q  <= `MSCR_RST_REG;
      end
      else if (ce)
      begin
         if (wr_tdata)
            tdata_q <= req.wdata[`MSCR_REG_W-1:0];
         if (wr_taddr)
            taddr_q <= req.wdata[`MSCR_REG_W-1:0];
         if (wr_tcmd)
            tcmd_q  <= req.wdata[`MSCR_REG_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cycle stamp: no power-state input, so Suspend cannot stop it

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         stamp_q <= `MSCR_RST_STAMP;
      else if (ce)
      begin
         if (wr_stamp)
            stamp_q <= req.wdata;
         else
            stamp_q <= stamp_q + 64'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event control and counters

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         ctl_q <= `MSCR_RST_REG;
      else if (ce && wr_ctl)
         ctl_q <= req.wdata[`MSCR_REG_W-1:0] & `MSCR_EVT_CTL_MASK;
   end

   always_comb
   begin
      ctl0.sel     = {ctl_q[`MSCR_CNT0_SEL_HI_BIT],
                      ctl_q[`MSCR_CNT0_SEL_LO_MSB:`MSCR_CNT0_SEL_LO_LSB]};
      ctl0.ctype   = ctl_q[`MSCR_CNT0_TYPE_BIT];
      ctl0.en_user = ctl_q[`MSCR_CNT0_USER_EN_BIT];
      ctl0.en_priv = ctl_q[`MSCR_CNT0_PRIV_EN_BIT];
      ctl1.sel     = {ctl_q[`MSCR_CNT1_SEL_HI_BIT],
                      ctl_q[`MSCR_CNT1_SEL_LO_MSB:`MSCR_CNT1_SEL_LO_LSB]};
      ctl1.ctype   = ctl_q[`MSCR_CNT1_TYPE_BIT];
      ctl1.en_user = ctl_q[`MSCR_CNT1_USER_EN_BIT];
      ctl1.en_priv = ctl_q[`MSCR_CNT1_PRIV_EN_BIT];
   end

   assign evt_sel0 = ctl0.sel;
   assign evt_sel1 = ctl1.sel;

   mscr_event_counter #(.WIDTH(EVT_W)) u_cnt0 (
      .core_clk                (core_clk),
      .nrst                    (nrst),
      .ce                      (ce),
      .ctl                     (ctl0),
      .current_privilege_level (current_privilege_level),
      .event_hit               (event_hit[0]),
      .wr_en                   (wr_cnt0),
      .wr_data                 (req.wdata[EVT_W-1:0]),
      .count_q                 (cnt0_q)
   );

   mscr_event_counter #(.WIDTH(EVT_W)) u_cnt1 (
      .core_clk                (core_clk),
      .nrst                    (nrst),
      .ce                      (ce),
      .ctl                     (ctl1),
      .current_privilege_level (current_privilege_level),
      .event_hit               (event_hit[1]),
      .wr_en                   (wr_cnt1),
      .wr_data                 (req.wdata[EVT_W-1:0]),
      .count_q                 (cnt1_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   AST_STAMP_STEP: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && !wr_stamp) |=> stamp_q == $past(stamp_q) + 64'h1)
      else $error("stamp did not advance by one");

   AST_STAMP_LOAD: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && wr_stamp) |=> stamp_q == $past(req.wdata))
      else $error("stamp write not loaded");

   AST_STAMP_READ: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && req.valid && req.opcode == `MSCR_OPC_READ_STAMP && !fault)
      |=> rsp.done && !rsp.fault && rsp.rdata == $past(stamp_q))
      else $error("stamp read returned wrong value");

   AST_MODEL_PRIV: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && req.valid && current_privilege_level != `MSCR_TOP_LVL &&
       (req.opcode == `MSCR_OPC_READ_MODEL ||
        req.opcode == `MSCR_OPC_WRITE_MODEL))
      |=> rsp.fault && $stable(ctl_q) && $stable(tdata_q))
      else $error("model access allowed above level zero");

   AST_STAMP_RESTRICT: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && req.valid && req.opcode == `MSCR_OPC_READ_STAMP)
      |=> rsp.fault == ($past(stamp_restrict) &&
                        $past(current_privilege_level) != `MSCR_TOP_LVL))
      else $error("stamp restriction wrong");

   AST_UNMAPPED: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && req.valid && !idx_map &&
       req.opcode == `MSCR_OPC_WRITE_MODEL)
      |=> rsp.fault && $stable(ctl_q) && $stable(tcmd_q))
      else $error("unmapped index did not fault");

   AST_CNT_ZERO_EXT: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && req.valid && req.opcode == `MSCR_OPC_READ_EVENT)
      |=> rsp.rdata[`MSCR_DATA_W-1:EVT_W] == '0)
      else $error("counter read upper bits not zero");

   AST_CTL_RSVD: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (ce && wr_ctl) |=> (ctl_q & ~`MSCR_EVT_CTL_MASK) == 32'h0000_0000
      ##1 (ctl_q & ~`MSCR_EVT_CTL_MASK) == 32'h0000_0000)
      else $error("reserved control bits set");

endmodule // mscr_unit

// [test/mscr_core_model.sv]
// Core-side model that issues the register instructions
`timescale 1ns/1ps

module mscr_core_model
   import mscr_pkg::*;
(
   // Clock and cycle count
   input  wire          core_clk,
   input  wire [31:0]   cyc_q,
   // Request and answer
   output mscr_req_s    req,
   input  mscr_rsp_s    rsp
);

   initial req = '0;

   ////////////////////////////////////////////////////////////////////////
   // One strobe per instruction, then a bounded wait for the answer
   task automatic exec(input logic [15:0] opc, input logic [31:0] idx,
                       input logic [63:0] wd, output mscr_rsp_s r,
                       output logic [31:0] t);
      int n;
      r = '0;
      @(negedge core_clk);
      req = '{valid: 1'b1, opcode: opc, index: idx, wdata: wd};
      @(negedge core_clk);
      t = cyc_q;
      // Released fields show garbage, never the last value
      req = '{valid: 1'b0, opcode: ~opc, index: ~idx, wdata: ~wd};
      // The answer stands one cycle only, so look before waiting again
      for (n = 0; n < 8 && rsp.done !== 1'b1; n++)
         @(negedge core_clk);
      if (rsp.done === 1'b1)
         r = rsp;
   endtask

endmodule // mscr_core_model

// [test/mscr_unit_test.sv]
// Self-checking bench of the model-specific register unit
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      n_compared++; \
      if ((a) !== (b)) \
      begin \
         failures++; \
         $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
      end \
   end

module mscr_unit_test
   import mscr_pkg::*;
;
   logic          core_clk       = 1'b0;
   logic          nrst           = 1'b0;
   logic          ce             = 1'b1;
   logic [1:0]    current_privilege_level = 2'h0;
   logic          stamp_restrict = 1'b0;
   logic          counter_open   = 1'b0;
   logic [1:0]    event_hit      = 2'h0;
   mscr_req_s     req;
   mscr_rsp_s     rsp;
   logic [6:0]    evt_sel0;
   logic [6:0]    evt_sel1;
   logic [31:0]   cyc_q          = 32'h0;
   logic [15:0]   seed_q         = 16'h4EE2;
   int            failures       = 0;
   int            n_compared     = 0;
   int            n;
   mscr_rsp_s     r;
   logic [31:0]   t0;
   logic [31:0]   t1;
   logic [63:0]   x;
   logic [31:0]   idx_tab [7] = '{32'h3, 32'h4, 32'h5, 32'h10, 32'h11,
                                  32'h12, 32'h13};

   mscr_unit u_mscr_unit (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .req(req), .current_privilege_level(current_privilege_level),
      .stamp_restrict(stamp_restrict),
      .counter_open(counter_open), .event_hit(event_hit), .rsp(rsp),
      .evt_sel0(evt_sel0), .evt_sel1(evt_sel1));

   mscr_core_model u_mscr_core_model (.core_clk(core_clk), .cyc_q(cyc_q),
      .req(req), .rsp(rsp));

   always #12.5 core_clk = ~core_clk;

   // Cycle count; the ceiling cuts a hang short
   always @(posedge core_clk)
   begin
      cyc_q <= cyc_q + 32'h1;
      if (cyc_q === 32'h0000_4E20)
      begin
         failures++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction

   task automatic rnd64(output logic [63:0] v);
      repeat (4)
      begin
         seed_q = lfsr(seed_q);
         v = {v[47:0], seed_q};
      end
   endtask

   // Readback of a written value: narrow registers keep low bits only
   function automatic logic [63:0] exp_model(input logic [31:0] idx,
                                             input logic [63:0] wd);
      case (idx)
         32'h3, 32'h4, 32'h5: return {32'h0, wd[31:0]};
         32'h11:              return {32'h0, wd[31:0] & 32'h05FF_05FF};
         32'h12, 32'h13:      return {16'h0, wd[47:0]};
         default:             return wd;
      endcase
   endfunction

   function automatic logic exp_fault(input logic [15:0] opc,
                                      input logic [31:0] idx);
      logic unpriv;
      unpriv = (current_privilege_level != 2'h0);
      case (opc)
         16'h0F30, 16'h0F32: return unpriv || !(idx inside
            {32'h3, 32'h4, 32'h5, [32'h10:32'h13]});
         16'h0F31: return stamp_restrict && unpriv;
         16'h0F33: return (!counter_open && unpriv) || idx > 32'h1;
         default:  return 1'b1;
      endcase
   endfunction

   task automatic op(input logic [15:0] opc, input logic [31:0] idx,
                     input logic [63:0] wd);
      u_mscr_core_model.exec(opc, idx, wd, r, t1);
      `CHK(r.done, 1'b1)
      `CHK(r.fault, exp_fault(opc, idx))
      if (r.fault === 1'b1) `CHK(r.rdata, 64'h0)
   endtask

   task automatic end_of_test();
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge core_clk);
      nrst = 1'b1;
      foreach (idx_tab[i])
      begin
         op(16'h0F32, idx_tab[i], 64'h0);
         if (idx_tab[i] != 32'h10) `CHK(r.rdata, 64'h0)
      end
      // Random write and readback; counting kept off by clearing enables
      repeat (3) foreach (idx_tab[i])
      begin
         if (idx_tab[i] != 32'h10)
         begin
            rnd64(x);
            if (idx_tab[i] == 32'h11) x[31:0] &= 32'hFF3F_FF3F;
            op(16'h0F30, idx_tab[i], x);
            op(16'h0F32, idx_tab[i], 64'h0);
            `CHK(r.rdata, exp_model(idx_tab[i], x))
            if (idx_tab[i] == 32'h11)
               `CHK({evt_sel1, evt_sel0}, {x[26], x[21:16], x[10], x[5:0]})
         end
      end
      // Stamp load, then both read paths; the corner wraps 64 bits
      for (int s = 0; s < 2; s++)
      begin
         rnd64(x);
         if (s == 1) x = 64'hFFFF_FFFF_FFFF_FFFE;
         op(16'h0F30, 32'h10, x);
         t0 = t1;
         repeat (seed_q[3:0]) @(negedge core_clk);
         op(16'h0F31, 32'h0, 64'h0);
         `CHK(r.rdata, x + 64'(t1 - t0 - 32'h1))
         op(16'h0F32, 32'h10, 64'h0);
         `CHK(r.rdata, x + 64'(t1 - t0 - 32'h1))
      end
      // Clock enable low for five edges must freeze the stamp
      op(16'h0F30, 32'h10, x);
      t0 = t1;
      ce = 1'b0;
      repeat (5) @(negedge core_clk);
      ce = 1'b1;
      op(16'h0F31, 32'h0, 64'h0);
      `CHK(r.rdata, x + 64'(t1 - t0 - 32'h6))
      // Every level and flag; faulted writes must leave control alone
      for (int m = 0; m < 16; m++)
      begin
         {counter_open, stamp_restrict, current_privilege_level} = m[3:0];
         op(16'h0F31, 32'h0, 64'h0);
         op(16'h0F30, 32'h11, 64'(m));
         op(16'h0F33, 32'(m[0]), 64'h0);
         op(16'h0F33, 32'h2, 64'h0);
      end
      current_privilege_level = 2'h0;
      op(16'h0F32, 32'h6, 64'h0);
      op(16'h0F30, 32'h14, 64'hFF);
      op(16'h0F34, 32'h11, 64'h0);
      op(16'h0F32, 32'h11, 64'h0);
      `CHK(r.rdata, 64'hC)
      // Counter 0 times clocks at all levels, counter 1 user events only
      op(16'h0F30, 32'h11, 64'h0080_01C0);
      op(16'h0F30, 32'h13, 64'hFFFF_0000_0000_0000);
      op(16'h0F30, 32'h12, 64'hABCD_FFFF_FFFF_FFF0);
      t0 = t1;
      n = 0;
      for (int c = 0; c < 40; c++)
      begin
         @(negedge core_clk);
         seed_q = lfsr(seed_q);
         current_privilege_level = c[3] ? 2'h3 : 2'h1;
         event_hit = seed_q[1:0];
         if (c[3] && seed_q[1]) n++;
      end
      @(negedge core_clk);
      event_hit = 2'h0;
      counter_open = 1'b1;
      op(16'h0F33, 32'h1, 64'h0);
      `CHK(r.rdata, 64'(n))
      op(16'h0F33, 32'h0, 64'h0);
      `CHK(r.rdata, {16'h0, 48'hFFFF_FFFF_FFF0 + 48'(t1 - t0 - 32'h1)})
      end_of_test();
   end

endmodule // mscr_unit_test
